// ---- src/usb_cmd_params.svh ----
// Command codes, field positions, lengths and byte offsets of the command port.
`ifndef USB_CMD_PARAMS_SVH
`define USB_CMD_PARAMS_SVH
// =============================================================
// Command groups, selected by the high nibble of the code.
`define GRP_BUF_WR 4'h0
`define GRP_BUF_RD 4'h1
`define GRP_CFG_WR 4'h2
`define GRP_CFG_RD 4'h3
`define GRP_STALL 4'h4
`define GRP_STAT 4'h5
`define GRP_VALID 4'h6
`define GRP_CLEAR 4'h7
`define GRP_UNSTALL 4'h8
// =============================================================
// Register command pairs, write code even and read code odd, then the single reset and image codes.
`define CODE_ADDR 8'hb6
`define CODE_MODE 8'hb8
`define CODE_HWCFG 8'hba
`define CODE_INTEN 8'hc2
`define CODE_DMACFG 8'hf0
`define CODE_DMACNT 8'hf2
`define CODE_RESET 8'hf6
`define CODE_IMAGE 8'hd0
// Endpoint indices with no legal buffer write and validate command (0) or buffer read and clear command (1).
`define EP_CTRL_OUT 4'h0
`define EP_CTRL_IN 4'h1
// =============================================================
// Byte offsets of each register inside the register byte file.
`define BASE_ADDR 4'h0
`define BASE_MODE 4'h1
`define BASE_HWCFG 4'h2
`define BASE_INTEN 4'h4
`define BASE_DMACFG 4'h8
`define BASE_DMACNT 4'ha
// =============================================================
// Transfer lengths in bytes.
`define LEN_ONE 11'h001
`define LEN_TWO 11'h002
`define LEN_FOUR 11'h004
`define LEN_HDR 11'h002
`define LEN_BULK 11'h040
`define LEN_ISO 11'h3ff
// Isochronous flag position in an endpoint configuration byte.
`define CFG_ISO_BIT 4
`endif

// ---- src/usb_cmd_pkg.sv ----
// Types shared by the command port: commands, actions and stream entries.
package usb_cmd_pkg;
    // Kind of the command in progress.
    typedef enum logic [3:0] {
        CK_NONE, CK_BUF_WR, CK_BUF_RD, CK_CFG_WR, CK_CFG_RD, CK_STALL, CK_UNSTALL,
        CK_STAT_RD, CK_IMG_RD, CK_VALID, CK_CLEAR, CK_REG_WR, CK_REG_RD, CK_RESET
    } cmd_kind_e;
    // Endpoint operation carried by a no-data command.
    typedef enum logic [1:0] {OP_STALL, OP_UNSTALL, OP_VALID, OP_CLEAR} ep_op_e;
    // Decoded command.
    typedef struct packed {
        cmd_kind_e kind;
        logic [3:0] ep;
        logic [3:0] base;
        logic [10:0] len;
    } cmd_s;
    // One host access on the parallel port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic a0;
        logic [15:0] data;
    } bus_req_s;
    // Pulse to the endpoint logic.
    typedef struct packed {
        logic valid;
        ep_op_e op;
        logic [3:0] ep;
    } ep_action_s;
    // One entry of the endpoint write stream.
    typedef struct packed {
        logic [3:0] ep;
        logic [15:0] data;
        logic hiValid;
        logic header;
        logic last;
    } wr_entry_s;
    // Register file view; byte 0 is the device address.
    typedef struct packed {
        logic [15:0] dmaCnt;
        logic [15:0] dmaCfg;
        logic [31:0] intEn;
        logic [15:0] hwCfg;
        logic [7:0] mode;
        logic [7:0] devAddr;
    } reg_file_s;
endpackage

// ---- src/usb_cmd_port.sv ----
// Command interpreter behind the parallel host port of the USB controller.
// Operation
// - A0 high takes low byte as command.
// - Commands without data act at once.
// - A0 low moves data for current command.
// - Multi-byte registers go least significant first.
// - Wide mode ignores upper and undefined bytes.
// - Odd packet write drops final upper byte; buffer reads pass it on.
// - Buffer starts with two byte count.
// - Codes 20 to 2F write endpoint configuration.
// - Codes 30 to 3F read endpoint configuration.
// - Codes 01 to 0F load IN buffers.
// - Codes 10, 12 to 1F read OUT buffers.
// - Codes 40 to 4F stall endpoints.
// - Codes 80 to 8F remove stalls.
// - Codes 50 to 5F return live status.
// - Codes 61 to 6F validate IN buffers.
// - Codes 70, 72 to 7F clear OUT buffers.
// - Code D0 returns the status image.
// - Image read changes no status bits.
// - Wide transfer count is (N+1) DIV 2.
`include "usb_cmd_params.svh"
module usb_cmd_port (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host parallel port.
    input wire usb_cmd_pkg::bus_req_s bus,
    input wire logic wide,
    output logic busReady,
    output logic [15:0] dataOut,
    output logic rdValid,
    // Endpoint control and configuration.
    output usb_cmd_pkg::ep_action_s epAction,
    output logic [15:0][7:0] epConfig,
    output usb_cmd_pkg::reg_file_s regFile,
    // Endpoint status.
    output logic [3:0] statusIdx,
    input wire logic [7:0] statusByte,
    output logic statusRead,
    input wire logic [7:0] imageByte,
    // Endpoint write stream.
    output usb_cmd_pkg::wr_entry_s fifoWr,
    output logic fifoWrValid,
    input wire logic fifoWrReady,
    // Endpoint read port, answered in the same cycle.
    output logic fifoRdReq,
    output logic [3:0] fifoRdEp,
    input wire logic [15:0] fifoRdData
);
    // =========================================================
    // Decoding helpers.
    // Maps a code to its command; illegal codes decode to no command.
    function automatic usb_cmd_pkg::cmd_s decode(input logic [7:0] code);
        usb_cmd_pkg::cmd_s c;
        c = '0;
        c.ep = code[3:0];
        case (code[7:4])
            `GRP_BUF_WR: if (code[3:0] != `EP_CTRL_OUT) c.kind = usb_cmd_pkg::CK_BUF_WR;
            `GRP_BUF_RD: if (code[3:0] != `EP_CTRL_IN) c.kind = usb_cmd_pkg::CK_BUF_RD;
            `GRP_CFG_WR: c.kind = usb_cmd_pkg::CK_CFG_WR;
            `GRP_CFG_RD: c.kind = usb_cmd_pkg::CK_CFG_RD;
            `GRP_STALL: c.kind = usb_cmd_pkg::CK_STALL;
            `GRP_STAT: c.kind = usb_cmd_pkg::CK_STAT_RD;
            `GRP_VALID: if (code[3:0] != `EP_CTRL_OUT) c.kind = usb_cmd_pkg::CK_VALID;
            `GRP_CLEAR: if (code[3:0] != `EP_CTRL_IN) c.kind = usb_cmd_pkg::CK_CLEAR;
            `GRP_UNSTALL: c.kind = usb_cmd_pkg::CK_UNSTALL;
            default: begin
                // Register pairs share one entry; bit 0 picks read or write.
                c.kind = code[0] ? usb_cmd_pkg::CK_REG_RD : usb_cmd_pkg::CK_REG_WR;
                case ({code[7:1], 1'b0})
                    `CODE_ADDR: begin
                        c.base = `BASE_ADDR;
                        c.len = `LEN_ONE;
                    end
                    `CODE_MODE: begin
                        c.base = `BASE_MODE;
                        c.len = `LEN_ONE;
                    end
                    `CODE_HWCFG: begin
                        c.base = `BASE_HWCFG;
                        c.len = `LEN_TWO;
                    end
                    `CODE_INTEN: begin
                        c.base = `BASE_INTEN;
                        c.len = `LEN_FOUR;
                    end
                    `CODE_DMACFG: begin
                        c.base = `BASE_DMACFG;
                        c.len = `LEN_TWO;
                    end
                    `CODE_DMACNT: begin
                        c.base = `BASE_DMACNT;
                        c.len = `LEN_TWO;
                    end
                    default: c.kind = usb_cmd_pkg::CK_NONE;
                endcase
                if (code == `CODE_RESET) c.kind = usb_cmd_pkg::CK_RESET;
                if (code == `CODE_IMAGE) c.kind = usb_cmd_pkg::CK_IMG_RD;
            end
        endcase
        // Buffers open with the count header; single-byte reads take one byte.
        if (c.kind == usb_cmd_pkg::CK_BUF_WR || c.kind == usb_cmd_pkg::CK_BUF_RD) c.len = `LEN_HDR;
        if (c.kind inside {usb_cmd_pkg::CK_CFG_WR, usb_cmd_pkg::CK_CFG_RD,
                usb_cmd_pkg::CK_STAT_RD, usb_cmd_pkg::CK_IMG_RD}) c.len = `LEN_ONE;
        return c;
    endfunction
    // Total bytes of a buffer transfer, header included, capped by endpoint type.
    function automatic logic [10:0] bufTotal(input logic [15:0] n, input logic [3:0] ep,
            input logic [7:0] cfg);
        logic [10:0] lim;
        lim = (ep > `EP_CTRL_IN && cfg[`CFG_ISO_BIT]) ? `LEN_ISO : `LEN_BULK;
        return `LEN_HDR + ((n > {5'h00, lim}) ? lim : n[10:0]);
    endfunction
    // =========================================================
    // State and strobes.
    usb_cmd_pkg::cmd_s cur, next_cur; // Command in progress.
    logic [10:0] pos, next_pos; // Bytes already moved in the data phase.
    logic [10:0] total, next_total; // Bytes the command may move.
    logic [7:0] cntLo, next_cntLo; // Count low byte held in 8-bit mode.
    logic [15:0][7:0] next_cfg;
    logic [11:0][7:0] regBytes, next_regs; // Register file as bytes.
    usb_cmd_pkg::ep_action_s next_action;
    logic [15:0] next_dataOut;
    logic next_rdValid;
    logic cmdWr, dataWr, dataRd; // Decoded host strobes.
    logic live, hiLive, take; // Byte in range, upper byte in range, access taken.
    logic [10:0] step; // Bytes per transfer.
    logic [3:0] idx, idxHi; // Register byte addresses.
    logic [15:0] hdrSrc; // Word carrying the count header.
    logic push, bufReady;
    usb_cmd_pkg::wr_entry_s pushEntry;
    logic [7:0] cfgSel; // Configuration byte of the current endpoint.
    assign cmdWr = bus.wr && bus.a0;
    assign dataWr = bus.wr && !bus.a0;
    assign dataRd = bus.rd && !bus.a0;
    assign step = wide ? `LEN_TWO : `LEN_ONE;
    assign live = pos < total;
    assign hiLive = wide && (pos + `LEN_ONE < total);
    assign idx = cur.base + pos[3:0];
    assign idxHi = idx + 4'h1;
    assign cfgSel = epConfig[cur.ep];
    assign statusIdx = cur.ep;
    assign fifoRdEp = cur.ep;
    assign regFile = usb_cmd_pkg::reg_file_s'(regBytes);
    assign hdrSrc = (cur.kind == usb_cmd_pkg::CK_BUF_RD) ? fifoRdData : bus.data;
    // =========================================================
    // Command interpreter: next values.
    // A new command always wins, so a host can abandon any transfer at will.
    always_comb begin
        next_cur = cur;
        next_pos = pos;
        next_total = total;
        next_cntLo = cntLo;
        next_cfg = epConfig;
        next_regs = regBytes;
        next_action = '0;
        next_dataOut = dataOut;
        next_rdValid = 1'b0;
        push = 1'b0;
        pushEntry = '0;
        fifoRdReq = 1'b0;
        statusRead = 1'b0;
        take = 1'b0;
        if (cmdWr) begin
            // Upper bus byte is never looked at here.
            next_cur = decode(bus.data[7:0]);
            next_pos = '0;
            next_total = next_cur.len;
            next_action.ep = next_cur.ep;
            // Stall, unstall, validate and clear fire their pulse on the next edge.
            case (next_cur.kind)
                usb_cmd_pkg::CK_STALL: next_action.valid = 1'b1;
                usb_cmd_pkg::CK_UNSTALL: begin
                    next_action.valid = 1'b1;
                    next_action.op = usb_cmd_pkg::OP_UNSTALL;
                end
                usb_cmd_pkg::CK_VALID: begin
                    next_action.valid = 1'b1;
                    next_action.op = usb_cmd_pkg::OP_VALID;
                end
                usb_cmd_pkg::CK_CLEAR: begin
                    next_action.valid = 1'b1;
                    next_action.op = usb_cmd_pkg::OP_CLEAR;
                end
                usb_cmd_pkg::CK_RESET: begin
                    next_cfg = '0;
                    next_regs = '0;
                end
                default: ;
            endcase
        end else if (dataWr && live) begin
            take = 1'b1;
            case (cur.kind)
                usb_cmd_pkg::CK_CFG_WR: next_cfg[cur.ep] = bus.data[7:0];
                usb_cmd_pkg::CK_REG_WR: begin
                    next_regs[idx] = bus.data[7:0];
                    if (hiLive) next_regs[idxHi] = bus.data[15:8];
                end
                usb_cmd_pkg::CK_BUF_WR: begin
                    // A full buffer refuses the word; busReady warned the host.
                    take = bufReady;
                    push = bufReady;
                    pushEntry.ep = cur.ep;
                    pushEntry.header = pos < `LEN_HDR;
                    pushEntry.hiValid = hiLive || (wide && pos == '0);
                    pushEntry.data = {pushEntry.hiValid ? bus.data[15:8] : 8'h00,
                        bus.data[7:0]};
                    pushEntry.last = pos + step >= total && pos >= `LEN_HDR;
                end
                default: take = 1'b0;
            endcase
        end else if (dataRd) begin
            next_rdValid = 1'b1;
            next_dataOut = '0;
            if (live) begin
                take = 1'b1;
                case (cur.kind)
                    usb_cmd_pkg::CK_CFG_RD: next_dataOut = {8'h00, cfgSel};
                    usb_cmd_pkg::CK_REG_RD: next_dataOut = {hiLive ? regBytes[idxHi] : 8'h00,
                        regBytes[idx]};
                    usb_cmd_pkg::CK_STAT_RD: begin
                        statusRead = 1'b1;
                        next_dataOut = {8'h00, statusByte};
                    end
                    usb_cmd_pkg::CK_IMG_RD: next_dataOut = {8'h00, imageByte};
                    usb_cmd_pkg::CK_BUF_RD: begin
                        fifoRdReq = 1'b1;
                        next_dataOut = fifoRdData;
                    end
                    default: take = 1'b0;
                endcase
            end
        end
        // Count header sets the transfer length once both bytes are seen.
        if (take && (cur.kind == usb_cmd_pkg::CK_BUF_WR || cur.kind == usb_cmd_pkg::CK_BUF_RD)) begin
            if (pos == '0 && !wide) next_cntLo = hdrSrc[7:0];
            else if (pos == '0) next_total = bufTotal(hdrSrc, cur.ep, cfgSel);
            else if (pos == `LEN_ONE) next_total = bufTotal({hdrSrc[7:0], cntLo}, cur.ep, cfgSel);
        end
        if (take) next_pos = pos + step;
    end
    // Command interpreter: registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '0;
            pos <= '0;
            total <= '0;
            cntLo <= '0;
            epConfig <= '0;
            regBytes <= '0;
            epAction <= '0;
            dataOut <= '0;
            rdValid <= 1'b0;
        end else begin
            cur <= next_cur;
            pos <= next_pos;
            total <= next_total;
            cntLo <= next_cntLo;
            epConfig <= next_cfg;
            regBytes <= next_regs;
            epAction <= next_action;
            dataOut <= next_dataOut;
            rdValid <= next_rdValid;
        end
    end
    // =========================================================
    // Two-entry write buffer towards the endpoint memory.
    // Two entries let a host write land while the drain side stalls one cycle.
    usb_cmd_pkg::wr_entry_s [1:0] mem, next_mem;
    logic wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [1:0] fill, next_fill;
    logic pop;
    assign bufReady = fill != 2'h2;
    assign busReady = bufReady;
    assign fifoWrValid = fill != 2'h0;
    assign fifoWr = mem[rdPtr];
    assign pop = fifoWrValid && fifoWrReady;
    // Buffer pointers and storage: next values.
    always_comb begin
        next_mem = mem;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        if (push) begin
            next_mem[wrPtr] = pushEntry;
            next_wrPtr = !wrPtr;
        end
        if (pop) next_rdPtr = !rdPtr;
        next_fill = fill + {1'b0, push} - {1'b0, pop};
    end
    // Buffer pointers and storage: registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem <= '0;
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            fill <= 2'h0;
        end else begin
            mem <= next_mem;
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            fill <= next_fill;
        end
    end
    // =========================================================
    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence cfgWrSeq;
        cmdWr && bus.data[7:4] == `GRP_CFG_WR ##1 dataWr;
    endsequence
    sequence resetCmd;
        cmdWr && bus.data[7:0] == `CODE_RESET;
    endsequence
    chk_stall_pulse: assert property (cmdWr && bus.data[7:4] == `GRP_STALL |=>
        epAction.valid && epAction.op == usb_cmd_pkg::OP_STALL
        && epAction.ep == $past(bus.data[3:0]))
        else $error("stall command gave no stall pulse");
    chk_unstall_pulse: assert property (cmdWr && bus.data[7:4] == `GRP_UNSTALL |=>
        epAction.valid && epAction.op == usb_cmd_pkg::OP_UNSTALL)
        else $error("unstall command gave no unstall pulse");
    chk_validate_pulse: assert property (cmdWr && bus.data[7:4] == `GRP_VALID
        && bus.data[3:0] != 4'h0 |=> epAction.valid && epAction.op == usb_cmd_pkg::OP_VALID)
        else $error("validate command gave no pulse");
    chk_clear_pulse: assert property (cmdWr && bus.data[7:4] == `GRP_CLEAR
        && bus.data[3:0] != 4'h1 |=> epAction.valid && epAction.op == usb_cmd_pkg::OP_CLEAR)
        else $error("clear command gave no pulse");
    chk_cfg_write: assert property (cfgWrSeq |=> epConfig[$past(cur.ep)] == $past(bus.data[7:0]))
        else $error("configuration byte not stored");
    chk_cfg_read: assert property (cur.kind == usb_cmd_pkg::CK_CFG_RD && dataRd && pos == '0
        |=> rdValid && dataOut == {8'h00, $past(cfgSel)})
        else $error("configuration read returned wrong byte");
    chk_header_first: assert property (push && pos < `LEN_HDR |-> pushEntry.header)
        else $error("count header not marked");
    chk_odd_upper: assert property (push && wide && pos + `LEN_ONE == total
        && pos >= `LEN_HDR |-> !pushEntry.hiValid && pushEntry.last)
        else $error("odd final upper byte passed on");
    chk_stray_data: assert property (cur.kind == usb_cmd_pkg::CK_NONE && dataWr && !cmdWr
        |=> $stable(epConfig) && $stable(regBytes) && !$past(push))
        else $error("stray data changed state");
    chk_image_quiet: assert property (cur.kind == usb_cmd_pkg::CK_IMG_RD && dataRd && live
        |-> !statusRead ##1 dataOut == {8'h00, $past(imageByte)})
        else $error("image read disturbed status or returned wrong byte");
    chk_reset_all: assert property (resetCmd |=> regBytes == '0 && epConfig == '0
        && cur.kind == usb_cmd_pkg::CK_RESET)
        else $error("reset command left registers set");
endmodule

// ---- verif/ep_side_model.sv ----
// Endpoint-side model: drains the write stream and answers status and buffer reads.
module ep_side_model (
    // Clock.
    input wire logic clk,
    // Test control: hold the drain off to stall the stream.
    input wire logic holdOff,
    // Write stream from the port.
    input wire usb_cmd_pkg::wr_entry_s fifoWr,
    input wire logic fifoWrValid,
    output logic fifoWrReady,
    // Read strobes from the port, counted to show which reads reach this side.
    input wire logic statusRead,
    input wire logic fifoRdReq,
    input wire logic [3:0] fifoRdEp,
    // Read side answers.
    input wire logic [3:0] statusIdx,
    output logic [7:0] statusByte,
    output logic [7:0] imageByte,
    output logic [15:0] fifoRdData
);
    timeunit 1ns;
    timeprecision 100ps;
    // Entries taken from the stream, kept in arrival order.
    usb_cmd_pkg::wr_entry_s got[$];
    // Live status reads seen; an image read must not add to this count.
    int statusReads = 0;
    // Buffer reads requested, and the endpoint of the latest one.
    int rdReqs = 0;
    logic [3:0] lastRdEp = 4'h0;
    // The status byte carries its own index, so a wrong index shows up at once.
    assign statusByte = {4'h5, statusIdx};
    assign imageByte = 8'h3c;
    // Every buffer word reads as two: a two-byte count, then one payload word.
    assign fifoRdData = 16'h0002;
    assign fifoWrReady = !holdOff;
    // ==========================================================
    // Capture on every accepted transfer edge.
    always @(posedge clk) begin
        if (fifoWrValid && fifoWrReady) begin
            got.push_back(fifoWr);
        end
        // Strobes are combinational, so they are counted at the edge that takes them.
        if (statusRead) begin
            statusReads++;
        end
        if (fifoRdReq) begin
            rdReqs++;
            lastRdEp = fifoRdEp;
        end
    end
endmodule

// ---- verif/usb_cmd_port_tb.sv ----
// Self-checking bench for the command port.
module usb_cmd_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Signals.
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic wide = 1'b0;
    logic holdOff = 1'b0;
    usb_cmd_pkg::bus_req_s bus = '0;
    logic busReady, rdValid, statusRead, fifoWrValid, fifoWrReady, fifoRdReq;
    logic [15:0] dataOut, fifoRdData;
    usb_cmd_pkg::ep_action_s epAction;
    logic [15:0][7:0] epConfig;
    usb_cmd_pkg::reg_file_s regFile;
    logic [3:0] statusIdx, fifoRdEp;
    logic [7:0] statusByte, imageByte;
    usb_cmd_pkg::wr_entry_s fifoWr;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #2 clk = !clk;
    usb_cmd_port i_dut (.clk(clk), .rst_n(rstN), .bus(bus), .wide(wide),
        .busReady(busReady), .dataOut(dataOut), .rdValid(rdValid), .epAction(epAction),
        .epConfig(epConfig), .regFile(regFile), .statusIdx(statusIdx),
        .statusByte(statusByte), .statusRead(statusRead), .imageByte(imageByte),
        .fifoWr(fifoWr), .fifoWrValid(fifoWrValid), .fifoWrReady(fifoWrReady),
        .fifoRdReq(fifoRdReq), .fifoRdEp(fifoRdEp), .fifoRdData(fifoRdData));
    ep_side_model i_model (.clk(clk), .holdOff(holdOff), .fifoWr(fifoWr),
        .fifoWrValid(fifoWrValid), .fifoWrReady(fifoWrReady), .statusIdx(statusIdx),
        .statusRead(statusRead), .fifoRdReq(fifoRdReq), .fifoRdEp(fifoRdEp),
        .statusByte(statusByte), .imageByte(imageByte), .fifoRdData(fifoRdData));
    // ==========================================================
    // Verdict and checks.
    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // A hang is cut short well past the hundred or so cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    // ==========================================================
    // One host strobe; data writes wait for room, since a refused write is lost.
    task automatic acc(input logic w, input logic a, input logic [15:0] d);
        int n = 0;
        @(posedge clk);
        #1;
        while (w && !a && busReady !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        bus = '{wr: w, rd: !w, a0: a, data: d};
        @(posedge clk);
        #1;
        bus = '0;
    endtask
    task automatic cmd(input logic [15:0] c);
        acc(1'b1, 1'b1, c);
    endtask
    task automatic rdw(input string name, input logic [15:0] exp);
        acc(1'b0, 1'b0, 16'h0000);
        chk("rdValid", 16'h0001, {15'h0000, rdValid});
        chk(name, exp, dataOut);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_config();
        wide = 1'b0;
        cmd(16'h0022);
        acc(1'b1, 1'b0, 16'h0055);
        chk("epConfig2", 16'h0055, {8'h00, epConfig[2]});
        wide = 1'b1;
        cmd(16'hff32);
        rdw("cfgRead", 16'h0055);
    endtask
    task automatic t_actions();
        logic [7:0] codes[5] = '{8'h43, 8'h83, 8'h63, 8'h73, 8'h41};
        usb_cmd_pkg::ep_op_e ops[5] = '{usb_cmd_pkg::OP_STALL, usb_cmd_pkg::OP_UNSTALL,
            usb_cmd_pkg::OP_VALID, usb_cmd_pkg::OP_CLEAR, usb_cmd_pkg::OP_STALL};
        logic [3:0] eps[5] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h1};
        for (int i = 0; i < 5; i++) begin
            cmd({8'h00, codes[i]});
            chk("epAction", {9'h000, 1'b1, ops[i], eps[i]}, {9'h000, epAction});
        end
        // An undecoded code, since the host never issues the illegal ones.
        cmd(16'h0090);
        chk("illegalAction", 16'h0000, {9'h000, epAction});
    endtask
    task automatic t_regs();
        wide = 1'b0;
        cmd(16'h00ba);
        acc(1'b1, 1'b0, 16'h0034);
        acc(1'b1, 1'b0, 16'h0012);
        chk("hwCfg", 16'h1234, regFile.hwCfg);
        cmd(16'h00bb);
        rdw("hwCfgLo", 16'h0034);
        rdw("hwCfgHi", 16'h0012);
        wide = 1'b1;
        cmd(16'h00c2);
        acc(1'b1, 1'b0, 16'h5678);
        acc(1'b1, 1'b0, 16'h1234);
        cmd(16'h00c3);
        rdw("intEnLo", 16'h5678);
        rdw("intEnHi", 16'h1234);
        cmd(16'h00b6);
        acc(1'b1, 1'b0, 16'h12ab);
        cmd(16'h00f2);
        acc(1'b1, 1'b0, 16'hbeef);
        chk("devAddr", 16'h00ab, {8'h00, regFile.devAddr});
        chk("mode", 16'h0000, {8'h00, regFile.mode});
        chk("dmaCnt", 16'hbeef, regFile.dmaCnt);
        cmd(16'h00b7);
        rdw("devAddrRd", 16'h00ab);
        cmd(16'h00f6);
        @(posedge clk);
        #1;
        chk("resetIntEn", 16'h0000, regFile.intEn[15:0]);
        chk("resetDma", 16'h0000, regFile.dmaCnt);
        chk("resetCfg", 16'h0000, {8'h00, epConfig[2]});
    endtask
    task automatic t_status();
        cmd(16'h0055);
        rdw("liveStatus", 16'h0055);
        cmd(16'h00d0);
        rdw("imageStatus", 16'h003c);
        chk("statusReads", 16'h0001, 16'(i_model.statusReads));
    endtask
    task automatic t_bufwr();
        wide = 1'b1;
        holdOff = 1'b1;
        cmd(16'h0002);
        acc(1'b1, 1'b0, 16'h0003);
        acc(1'b1, 1'b0, 16'haabb);
        chk("fullRefuses", 16'h0000, {15'h0000, busReady});
        holdOff = 1'b0;
        acc(1'b1, 1'b0, 16'hccdd);
        acc(1'b1, 1'b0, 16'h9999);
        cmd(16'h0090);
        acc(1'b1, 1'b0, 16'h7777);
        repeat (4) @(posedge clk);
        #1;
        chk("entries", 16'h0003, 16'(i_model.got.size()));
        chk("header", 16'h0003, i_model.got[0].data);
        chk("hdrFlag", 16'h0001, {15'h0000, i_model.got[0].header});
        chk("oddLast", 16'h00dd, i_model.got[2].data);
        chk("oddFlags", 16'h0001, {14'h0000, i_model.got[2].hiValid, i_model.got[2].last});
        // Byte mode: the count arrives low byte first, then one payload byte.
        wide = 1'b0;
        cmd(16'h0001);
        acc(1'b1, 1'b0, 16'h0001);
        acc(1'b1, 1'b0, 16'h0000);
        acc(1'b1, 1'b0, 16'h005a);
        acc(1'b1, 1'b0, 16'h00ee);
        repeat (3) @(posedge clk);
        #1;
        chk("byteEntries", 16'h0006, 16'(i_model.got.size()));
        chk("byteHdr", 16'h0002, {14'h0000, i_model.got[4].header, i_model.got[5].header});
        chk("byteLast", 16'h005a, i_model.got[5].data);
        chk("byteFlags", 16'h0003, {11'h000, i_model.got[5].ep, i_model.got[5].last});
    endtask
    task automatic t_bufrd();
        wide = 1'b1;
        cmd(16'h0012);
        rdw("rdHeader", 16'h0002);
        rdw("rdPayload", 16'h0002);
        rdw("rdBeyond", 16'h0000);
        chk("rdReqs", 16'h0002, 16'(i_model.rdReqs));
        chk("rdEp", 16'h0002, {12'h000, i_model.lastRdEp});
    endtask
    // ==========================================================
    // Main sequence: reset held for ten cycles, then every scenario once.
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rstN = 1'b1;
        t_config();
        t_actions();
        t_regs();
        t_status();
        t_bufwr();
        t_bufrd();
        finish_test();
    end
endmodule
